// ==== hdl/siowat_top.sv ====
/*
 * Three-wire serial port with single-byte and automatic buffered
 * transfer, master or slave, behind an Avalon-MM slave with waitrequest.
 * Assumes one 25 MHz clock, an asynchronous active-high reset, and that
 * pins from outside are asynchronous and are synchronised here.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - Eight-bit words over clock, in, out lines
// - Shift out and sample in together
// - MSB or LSB first selectable
// - Master makes clock, slave follows pin
// - Auto run moves one to 32 bytes
// - Auto gap zero to 63 clock periods as master
// - Single run or repeating run
// - Divider ratios six, eight, sixteen, 32
// - Strobe out between bytes as master, busy holds off
// - One completion interrupt per finish
// - 32-byte buffer RAM feeds auto engine
// - Write to shift data starts transfer
// - Shift data read returns received byte
// - Reset clears shift data and count
// - Count tracks position, holds after stop
// - Count read-only, upper three bits zero
// - Disabled port stays fully quiet
// - Disable: out low, clock high, clear state
// - Auto select picks single or auto
// - Single stops at end, repeat restarts
// - Transmit disabled holds output low
module siowat_top #(
    parameter int unsigned ADDR_W = siowat_pkg::SIOWAT_ADDR_W
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    input  wire logic              serial_clock_line_in,
    output logic                   serial_clock_line_out,
    output logic                   serial_clock_line_oe_n,
    input  wire logic              serial_data_in,
    output logic                   serial_data_out,
    output logic                   strobe_out,
    input  wire logic              busy_in,
    output logic                   transfer_done_irq
);
    import siowat_pkg::*;

    // ==========================================================
    // Elaboration check
    if (ADDR_W < SIOWAT_ADDR_W) begin : g_chk
        $error("siowat_top: ADDR_W too small for register map");
    end

    // ==========================================================
    // Declarations
    logic [7:0]    mode_reg;        // operation_mode_reg
    logic [7:0]    status_reg;      // Writable status bits
    logic [1:0]    divisor_reg;     // Divider ratio select
    logic [4:0]    end_addr_reg;    // auto_end_address
    logic [5:0]    interval_reg;    // auto_interval_setting
    logic [7:0]    shift_reg;       // serial_shift_data
    logic [4:0]    count_reg;       // auto_transfer_address_count
    logic          tsf_reg;         // transfer_active_flag
    logic          irq_reg;         // Completion pulse
    logic          run_reg;         // Auto run in progress
    logic [2:0]    bit_reg;         // Bits done in byte
    logic [3:0]    div_reg;         // Divider count
    logic [6:0]    gap_reg;         // Gap half periods
    logic          sck_reg;         // Master clock level
    logic          oe_n_reg;        // Clock pin drive, low drives
    logic          dout_reg;        // Data pin level
    logic          strobe_reg;      // Strobe pin level
    logic          wait_reg;        // Bus waitrequest
    logic [31:0]   rdata_reg;       // Bus read data
    logic [2:0]    sck_sync;        // Clock pin sync and edge stage
    logic [1:0]    din_sync;        // Data pin sync
    logic [1:0]    busy_sync;       // Busy pin sync
    logic [7:0]    buf_mem [0:SIOWAT_BUF_DEPTH-1]; // Buffer RAM
    siowat_state_t state_reg;       // Engine state

    logic [15:0]   idx;             // Register index
    logic          wr_take;         // Write takes effect
    logic          en, auto_m, master, lsb;
    logic          busy_active, tick, fall_ev, rise_ev;
    logic          start_single, start_auto, last_byte;
    logic [3:0]    half;            // Half period in cycles
    logic [7:0]    shifted;         // Shift register after a rise
    logic [5:0]    gap_len;         // Gap length in periods
    logic [7:0]    rd_byte;         // Read mux result

    assign idx     = address[17:2];
    assign wr_take = write && !wait_reg && byteenable[0];
    assign en      = mode_reg[MODE_ENABLE_BIT];
    assign auto_m  = mode_reg[MODE_AUTO_BIT];
    assign master  = mode_reg[MODE_MASTER_BIT];
    assign lsb     = mode_reg[MODE_LSB_BIT];

    // ==========================================================
    // Pin synchronisers, two flops before use
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sck_sync  <= 3'h7;
            din_sync  <= 2'h0;
            busy_sync <= 2'h0;
        end else begin
            sck_sync  <= {sck_sync[1:0], serial_clock_line_in};
            din_sync  <= {din_sync[0], serial_data_in};
            busy_sync <= {busy_sync[0], busy_in};
        end
    end

    // Busy matches its programmed active level
    // busy hold detection
    assign busy_active = status_reg[STAT_BUSYE_BIT] &&
                         (busy_sync[1] == status_reg[STAT_BUSYLV_BIT]);

    // ==========================================================
    // Serial clock events
    // divider ratio select
    always_comb begin
        case (divisor_reg)
            2'h0:    half = HALF_DIV6;
            2'h1:    half = HALF_DIV8;
            2'h2:    half = HALF_DIV16;
            default: half = HALF_DIV32;
        endcase
    end
    assign tick = (div_reg + 4'h1 == half);
    // master divider or slave pin edges
    assign fall_ev = master ? (tick && sck_reg)
                            : (!sck_sync[1] && sck_sync[2]);
    assign rise_ev = master ? (tick && !sck_reg)
                            : (sck_sync[1] && !sck_sync[2]);
    // shift out and sample in together
    assign shifted = lsb
        ? {din_sync[1] && mode_reg[MODE_RX_BIT], shift_reg[7:1]}
        : {shift_reg[6:0], din_sync[1] && mode_reg[MODE_RX_BIT]};

    // Launch requests and gap length
    // write launches single byte
    assign start_single = wr_take && idx == IDX_SHIFT && en && !auto_m &&
                          !tsf_reg && state_reg == ST_IDLE;
    assign start_auto   = wr_take && idx == IDX_TRIGGER && en && auto_m &&
                          writedata[TRIG_START_BIT] && state_reg == ST_IDLE;
    assign last_byte    = count_reg == end_addr_reg;
    assign gap_len = (status_reg[STAT_STROBE_BIT] &&
                      interval_reg < STROBE_GAP) ? STROBE_GAP : interval_reg;

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_reg     <= RST_BYTE;
            status_reg   <= RST_BYTE;
            divisor_reg  <= 2'h0;
            end_addr_reg <= 5'h00;
            interval_reg <= 6'h00;
        end else if (wr_take) begin
            case (idx)
                IDX_MODE:     mode_reg <= writedata[7:0] & MODE_WR_MASK;
                IDX_STATUS:   if (!tsf_reg) begin
                    status_reg <= writedata[7:0] & STAT_WR_MASK;
                end
                IDX_DIVISOR:  divisor_reg  <= writedata[1:0];
                IDX_END_ADDR: end_addr_reg <= writedata[4:0];
                IDX_INTERVAL: interval_reg <= writedata[5:0];
                default:      ;
            endcase
        end
    end

    // ==========================================================
    // Transfer engine
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            shift_reg <= RST_BYTE;
            count_reg <= RST_COUNT;
            tsf_reg   <= 1'b0;
            irq_reg   <= 1'b0;
            run_reg   <= 1'b0;
            bit_reg   <= 3'h0;
            gap_reg   <= 7'h00;
        end else if (!en) begin
            state_reg <= ST_IDLE;
            shift_reg <= RST_BYTE;
            count_reg <= RST_COUNT;
            tsf_reg   <= 1'b0;
            irq_reg   <= 1'b0;
            run_reg   <= 1'b0;
            bit_reg   <= 3'h0;
            gap_reg   <= 7'h00;
        end else begin
            irq_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_single) begin
                        shift_reg <= writedata[7:0];
                        tsf_reg   <= 1'b1;
                        state_reg <= ST_HOLD;
                    end else if (start_auto) begin
                        shift_reg <= buf_mem[count_reg];
                        tsf_reg   <= 1'b1;
                        run_reg   <= 1'b1;
                        state_reg <= ST_HOLD;
                    end
                    bit_reg <= 3'h0;
                end
                ST_HOLD: begin
                    if (!busy_active) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (rise_ev) begin
                        shift_reg <= shifted;
                        bit_reg   <= bit_reg + 3'h1;
                        gap_reg   <= 7'h00;
                        if (bit_reg == LAST_BIT) begin
                            if (!run_reg) begin
                                tsf_reg   <= 1'b0;
                                irq_reg   <= 1'b1;
                                state_reg <= ST_IDLE;
                            end else if (!last_byte) begin
                                count_reg <= count_reg + 5'h01;
                                state_reg <= ST_GAP;
                            end else if (mode_reg[MODE_REPEAT_BIT]) begin
                                count_reg <= RST_COUNT;
                                tsf_reg   <= 1'b0;
                                irq_reg   <= 1'b1;
                                state_reg <= ST_GAP;
                            end else begin
                                tsf_reg   <= 1'b0;
                                irq_reg   <= 1'b1;
                                run_reg   <= 1'b0;
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (master && gap_reg < {gap_len, 1'b0}) begin
                        if (tick) begin
                            gap_reg <= gap_reg + 7'h01;
                        end
                    end else if (!auto_m) begin
                        run_reg   <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else begin
                        shift_reg <= buf_mem[count_reg];
                        tsf_reg   <= 1'b1;
                        state_reg <= ST_HOLD;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Buffer RAM, engine write back wins over the bus
    // received bytes stored in place
    always_ff @(posedge clock) begin
        if (en && run_reg && state_reg == ST_SHIFT && rise_ev &&
            bit_reg == LAST_BIT) begin
            buf_mem[count_reg] <= shifted;
        end else if (en && wr_take && idx[15:5] == IDX_BUF_BASE[15:5]) begin
            buf_mem[idx[4:0]] <= writedata[7:0];
        end
    end

    // ==========================================================
    // Master clock divider and clock pin
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            div_reg  <= 4'h0;
            sck_reg  <= 1'b1;
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= !(en && master);
            if (!en || !master ||
                (state_reg != ST_SHIFT && state_reg != ST_GAP)) begin
                div_reg <= 4'h0;
                sck_reg <= 1'b1;
            end else begin
                div_reg <= tick ? 4'h0 : div_reg + 4'h1;
                if (tick && state_reg == ST_SHIFT) begin
                    sck_reg <= !sck_reg;
                end
            end
        end
    end

    // ==========================================================
    // Data and strobe pins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dout_reg   <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            if (!en || !mode_reg[MODE_TX_BIT]) begin
                dout_reg <= 1'b0;
            end else if ((state_reg == ST_HOLD && !busy_active) ||
                         (state_reg == ST_SHIFT && fall_ev &&
                          bit_reg != 3'h0)) begin
                dout_reg <= lsb ? shift_reg[0] : shift_reg[7];
            end
            strobe_reg <= en && master && status_reg[STAT_STROBE_BIT] &&
                          state_reg == ST_GAP && gap_reg < 7'h02;
        end
    end

    // ==========================================================
    // Read mux
    always_comb begin
        rd_byte = RST_BYTE;
        case (idx)
            IDX_MODE:     rd_byte = mode_reg;
            IDX_STATUS:   rd_byte = status_reg | {7'h00, tsf_reg};
            IDX_DIVISOR:  rd_byte = {6'h00, divisor_reg};
            IDX_END_ADDR: rd_byte = {3'h0, end_addr_reg};
            IDX_INTERVAL: rd_byte = {2'h0, interval_reg};
            IDX_SHIFT:    rd_byte = shift_reg;
            IDX_ADDR_CNT: rd_byte = {3'h0, count_reg};
            default: begin
                if (en && idx[15:5] == IDX_BUF_BASE[15:5]) begin
                    rd_byte = buf_mem[idx[4:0]];
                end
            end
        endcase
    end

    // ==========================================================
    // Avalon handshake, answer one cycle after the request
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !((read || write) && wait_reg);
            if (read && wait_reg) begin
                rdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign readdata               = rdata_reg;
    assign waitrequest            = wait_reg;
    assign serial_clock_line_out  = sck_reg;
    assign serial_clock_line_oe_n = oe_n_reg;
    assign serial_data_out        = dout_reg;
    assign strobe_out             = strobe_reg;
    assign transfer_done_irq      = irq_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_req;
        (read || write) && waitrequest;
    endsequence
    sequence s_ack;
        !waitrequest ##1 waitrequest;
    endsequence

    a_bus_one_wait: assert property (s_req |=> s_ack)
        else $error("bus answer not one cycle");
    a_single_launch: assert property (
        start_single |=> tsf_reg && state_reg == ST_HOLD)
        else $error("shift write did not launch");
    a_irq_drops_tsf: assert property (
        transfer_done_irq |-> !tsf_reg && $past(tsf_reg))
        else $error("active flag not cleared with irq");
    a_disable_clear: assert property (
        !en |=> count_reg == RST_COUNT && !tsf_reg && serial_clock_line_out)
        else $error("disable did not clear state");
    a_tx_off_low: assert property (
        !mode_reg[MODE_TX_BIT] |=> !serial_data_out)
        else $error("output not low with transmit off");
    a_eight_bits: assert property (
        state_reg == ST_SHIFT && rise_ev && bit_reg == LAST_BIT && !run_reg
        |=> state_reg == ST_IDLE && transfer_done_irq)
        else $error("byte did not end after eight bits");
    a_single_stop: assert property (
        transfer_done_irq && !mode_reg[MODE_REPEAT_BIT] && auto_m
        |-> count_reg == end_addr_reg && !run_reg)
        else $error("single run stopped at wrong count");
    a_busy_holds: assert property (
        state_reg == ST_HOLD && busy_active && en |=> state_reg == ST_HOLD)
        else $error("busy did not hold transfer");
    a_count_step: assert property (
        en && run_reg && state_reg == ST_SHIFT && rise_ev &&
        bit_reg == LAST_BIT && !last_byte
        |=> count_reg == $past(count_reg) + 5'h01)
        else $error("count did not advance");
    a_clock_oe: assert property (
        en && !master |=> serial_clock_line_oe_n)
        else $error("slave drove clock");
endmodule

// ==== hdl/siowat_pkg.sv ====
/*
 * Shared constants for the three-wire serial port with auto transfer:
 * register indices, field positions, reset values, divider ratios and
 * the engine state type.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per
 * register, byte address equal to four times the register index.
 */
package siowat_pkg;

    // ==========================================================
    // Bus geometry
    localparam int unsigned SIOWAT_ADDR_W    = 18;  // Byte address width
    localparam int unsigned SIOWAT_IDX_W     = 16;  // Register index width
    localparam int unsigned SIOWAT_BUF_DEPTH = 32;  // Buffer RAM bytes

    // ==========================================================
    // Register indices (byte address = 4 * index)
    localparam logic [15:0] IDX_MODE     = 16'hFF90; // operation_mode_reg
    localparam logic [15:0] IDX_STATUS   = 16'hFF91; // status_reg
    localparam logic [15:0] IDX_TRIGGER  = 16'hFF92; // trigger_reg
    localparam logic [15:0] IDX_DIVISOR  = 16'hFF93; // divisor_select_reg
    localparam logic [15:0] IDX_END_ADDR = 16'hFF94; // auto_end_address
    localparam logic [15:0] IDX_INTERVAL = 16'hFF95; // auto_interval_setting
    localparam logic [15:0] IDX_SHIFT    = 16'hFF96; // serial_shift_data
    localparam logic [15:0] IDX_ADDR_CNT = 16'hFF97; // address count, RO
    localparam logic [15:0] IDX_BUF_BASE = 16'hFA00; // Buffer RAM, 32 words

    // ==========================================================
    // operation_mode_reg fields
    localparam int unsigned MODE_ENABLE_BIT = 7;  // port_enable
    localparam int unsigned MODE_AUTO_BIT   = 6;  // auto_operation_select
    localparam int unsigned MODE_REPEAT_BIT = 5;  // repeat_select
    localparam int unsigned MODE_MASTER_BIT = 4;  // Master when one
    localparam int unsigned MODE_TX_BIT     = 3;  // transmit_enable
    localparam int unsigned MODE_RX_BIT     = 2;  // Receive enable
    localparam int unsigned MODE_LSB_BIT    = 1;  // LSB first when one
    localparam logic [7:0]  MODE_WR_MASK    = 8'hFE;

    // ==========================================================
    // status_reg fields
    localparam int unsigned STAT_STROBE_BIT = 5;  // Strobe enable
    localparam int unsigned STAT_BUSYE_BIT  = 4;  // Busy detect enable
    localparam int unsigned STAT_BUSYLV_BIT = 3;  // Busy active level
    localparam int unsigned STAT_TSF_BIT    = 0;  // transfer_active_flag
    localparam logic [7:0]  STAT_WR_MASK    = 8'h38;
    localparam int unsigned TRIG_START_BIT  = 0;  // Auto run start

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [4:0] RST_COUNT = 5'h00;

    // ==========================================================
    // Divider half periods for ratios 6, 8, 16 and 32
    localparam logic [3:0] HALF_DIV6  = 4'h3;
    localparam logic [3:0] HALF_DIV8  = 4'h4;
    localparam logic [3:0] HALF_DIV16 = 4'h8;
    localparam logic [3:0] HALF_DIV32 = 4'h0; // Wraps: 16 half cycles
    localparam logic [5:0] STROBE_GAP = 6'h02; // Least gap with strobe
    localparam logic [2:0] LAST_BIT   = 3'h7;

    // ==========================================================
    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_SHIFT,
        ST_GAP
    } siowat_state_t;

endpackage

// ==== sim/siowat_periph.sv ====
/*
 * Peripheral model: returns a fixed reply MSB first, captures bytes.
 * Assumes master mode, clock idling high, data steady at rising edge.
 */
`timescale 1ns/100ps
module siowat_periph #(
    parameter logic [7:0] REPLY = 8'h3C
) (
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       sdo,
    output logic            sdi,
    output logic [7:0]      got
);
    logic [7:0] rx_reg  = 8'h00; // Capture shifter
    logic [2:0] cnt_reg = 3'h0;  // Rising edges in frame
    logic [2:0] idx_reg = 3'h0;  // Reply bit on the line
    assign sdi = REPLY[3'h7 - idx_reg];
    // Eight rising edges make a byte
    always @(posedge sclk) begin
        if (!rst) begin
            rx_reg  <= {rx_reg[6:0], sdo};
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) got <= {rx_reg[6:0], sdo};
        end
    end
    // Next reply bit after falling clock
    always @(negedge sclk) idx_reg <= cnt_reg;
endmodule

// ==== sim/siowat_top_tb.sv ====
/*
 * Bench: Avalon tasks, peripheral model, byte compares.
 * Assumes the package, siowat_top and siowat_periph are compiled.
 */
`timescale 1ns/100ps
module siowat_top_tb;
    import siowat_pkg::*;
    logic        clock     = 1'b0;  // System clock
    logic        reset     = 1'b1;  // Async reset
    logic [17:0] address   = 18'h0; // Byte address
    logic        read      = 1'b0;
    logic        write     = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest, sclk, sdi, sdo, irq, stb;
    logic        stb_seen = 1'b0; // Strobe seen since start, never cleared
    logic [7:0]  got, q;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    siowat_top u_dut (
        .clock(clock), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'h1),
        .readdata(readdata), .waitrequest(waitrequest),
        .serial_clock_line_in(1'b1), .serial_clock_line_out(sclk),
        .serial_clock_line_oe_n(), .serial_data_in(sdi),
        .serial_data_out(sdo), .strobe_out(stb), .busy_in(1'b0),
        .transfer_done_irq(irq)
    );
    siowat_periph u_periph (
        .rst(reset), .sclk(sclk), .sdo(sdo), .sdi(sdi), .got(got)
    );
    initial forever #20 clock = ~clock;
    // Bus cycle, entered right after a rising edge
    task automatic acc(input bit w, input logic [15:0] i,
                       input logic [7:0] d);
        address   <= {i, 2'b00};
        writedata <= {24'h0, d};
        write     <= w;
        read      <= !w;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_irq;
        do @(negedge clock); while (irq !== 1'b1);
        @(posedge clock);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic summarize;
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard and strobe watch
    always @(posedge clock) begin
        cyc++;
        if (stb === 1'b1) stb_seen <= 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            summarize;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        acc(0, IDX_SHIFT, 8'h00);
        chk(q, RST_BYTE);
        acc(0, IDX_ADDR_CNT, 8'h00);
        chk(q, 8'h00);
        acc(0, 16'h0000, 8'h00);
        chk(q, 8'h00);
        $display("Test reset done");
        acc(1, IDX_DIVISOR, 8'h00);
        acc(1, IDX_MODE, 8'h9C);
        acc(1, IDX_SHIFT, 8'hA5);
        wait_irq;
        chk(got, 8'hA5);
        acc(0, IDX_SHIFT, 8'h00);
        chk(q, 8'h3C);
        acc(1, IDX_MODE, 8'h9E);
        acc(1, IDX_SHIFT, 8'h01);
        wait_irq;
        chk(got, 8'h80);
        $display("Test single done");
        acc(1, IDX_MODE, 8'hDC);
        acc(1, IDX_BUF_BASE, 8'h11);
        acc(1, IDX_BUF_BASE + 16'h0001, 8'h22);
        acc(1, IDX_END_ADDR, 8'h01);
        acc(1, IDX_INTERVAL, 8'h00);
        acc(1, IDX_STATUS, 8'h20);
        acc(1, IDX_TRIGGER, 8'h01);
        wait_irq;
        chk(got, 8'h22);
        chk({7'h0, stb_seen}, 8'h01);
        acc(0, IDX_ADDR_CNT, 8'h00);
        chk(q, 8'h01);
        acc(0, IDX_BUF_BASE, 8'h00);
        chk(q, 8'h3C);
        $display("Test auto done");
        acc(1, IDX_MODE, 8'h00);
        @(posedge clock);
        chk({7'h0, sdo}, 8'h00);
        chk({7'h0, sclk}, 8'h01);
        acc(0, IDX_ADDR_CNT, 8'h00);
        chk(q, 8'h00);
        acc(1, IDX_MODE, 8'h94);
        acc(1, IDX_SHIFT, 8'hFF);
        wait_irq;
        chk({7'h0, sdo}, 8'h00);
        acc(0, IDX_SHIFT, 8'h00);
        chk(q, 8'h3C);
        $display("Test disable done");
        summarize;
    end
endmodule
